// ==== rtl/card_xfer_defines.svh ====
`ifndef CARD_XFER_DEFINES_SVH
`define CARD_XFER_DEFINES_SVH

// ****************************************************************
// Word layout: 11 BCD digits, digit 0 is the sign, 4 bits each
// ****************************************************************
`define WORD_DIGITS      11
`define WORD_BITS        44
`define ADDR_BITS        14
`define STORE_SIZE_DEF   14'h0fa0
`define SIGN_LO          0
`define SIGN_HI          3
`define ADDR_LO          4
`define ADDR_HI          19
`define RELOAD_LO        20
`define RELOAD_HI        23
`define CTLW_LO          24
`define CTLW_HI          27
`define PAIRS_PER_WORD   4'h6
`define HIGH_DIGITS      4'h5

`endif

// ==== rtl/card_xfer_pkg.sv ====
package card_xfer_pkg;

    typedef enum logic [1:0]
    {
        DIR_INPUT,
        DIR_OUTPUT,
        DIR_FORMAT_LOAD
    } xfer_dir_type;

    typedef enum logic [1:0]
    {
        ALARM_NONE,
        ALARM_NO_ADDR,
        ALARM_NO_UNIT,
        ALARM_NO_FORMAT
    } alarm_type;

endpackage

// ==== rtl/punched_card_buffer_transfer.sv ====
`timescale 1ns/10ps
`include "card_xfer_defines.svh"

module punched_card_buffer_transfer
(
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire logic                       start,
    input  wire card_xfer_pkg::xfer_dir_type dir,
    input  wire logic [`WORD_BITS-1:0]      instr_word,
    input  wire logic [`WORD_BITS-1:0]      control_register,
    input  wire logic [`ADDR_BITS-1:0]      store_size,
    input  wire logic                       unit_present,
    input  wire logic                       format_selected,
    input  wire logic                       card_format_hold,
    input  wire logic [3:0]                 index_digits_sign,
    input  wire logic [`ADDR_BITS-1:0]      index_value,
    input  wire logic                       band_valid,
    output logic                            band_ready,
    input  wire logic [3:0]                 band_digit,
    input  wire logic                       band_done,
    output logic                            buf_valid,
    input  wire logic                       buf_ready,
    output logic [3:0]                      buf_digit,
    output logic                            mem_wr,
    output logic                            mem_rd,
    output logic [`ADDR_BITS-1:0]           mem_addr,
    output logic [`WORD_BITS-1:0]           mem_wdata,
    input  wire logic [`WORD_BITS-1:0]      mem_rdata,
    output logic [`WORD_BITS-1:0]           peripheral_command_register,
    output logic                            proc_clock_stop,
    output logic                            busy,
    output logic                            done,
    output logic                            control_word_fetch,
    output logic                            fetch_index_modify,
    output logic                            unit_release,
    output logic                            reload_hold,
    output logic                            format_hold,
    output card_xfer_pkg::alarm_type        alarm
);
    import card_xfer_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_IN_FILL,
        ST_IN_STORE,
        ST_OUT_LOAD,
        ST_OUT_PAIR,
        ST_OUT_HIGH,
        ST_FINISH
    } state_type;

    state_type               state_reg;
    logic [`WORD_BITS-1:0]   data_reg;
    logic [`WORD_BITS-1:0]   iface_reg;
    logic [`ADDR_BITS-1:0]   addr_reg;
    logic [3:0]              adder_reg;
    logic                    adder_full_reg;
    logic [3:0]              cnt_reg;
    logic [3:0]              reload_reg;
    logic                    ctlw_reg;
    logic                    format_run_reg;
    logic [3:0]              sign_next;
    logic                    idx_next;
    logic [`WORD_BITS-1:0]   store_word;
    logic                    addr_bad;
    logic                    ctl_word;

    // Two-entry buffer toward the peripheral
    logic [3:0]              fifo_mem [0:1];
    logic                    wr_ptr_reg;
    logic                    rd_ptr_reg;
    logic [1:0]              fifo_cnt_reg;
    logic                    fifo_push;
    logic                    fifo_pop;
    logic                    fifo_full;
    logic [3:0]              push_digit;

    assign fifo_full = (fifo_cnt_reg == 2'h2);
    assign buf_valid = (fifo_cnt_reg != 2'h0);
    assign buf_digit = fifo_mem[rd_ptr_reg];
    assign fifo_pop  = buf_valid && buf_ready;

    assign addr_bad = (addr_reg >= store_size);
    // Signs 6 and 7 share bits 3..1
    assign ctl_word = !ctlw_reg && (iface_reg[`SIGN_HI:`SIGN_LO+1] == 3'h3);

    // ****************************************************************
    // Input sign control
    // ****************************************************************
    always_comb
    begin
        sign_next = iface_reg[`SIGN_HI:`SIGN_LO];
        idx_next  = 1'b0;
        if ((reload_reg == 4'h8 || reload_reg == 4'h9)
            && (sign_next == 4'h8 || sign_next == 4'h9))
        begin
            sign_next = {3'h0, sign_next[0]};
            idx_next  = 1'b1;
        end
        store_word = {iface_reg[`WORD_BITS-1:4], sign_next};
        if (idx_next)
        begin
            store_word[`ADDR_HI:`ADDR_LO] =
                iface_reg[`ADDR_HI:`ADDR_LO] + {2'h0, index_value};
        end
    end

    // Band digits only move while the data register is being filled
    assign band_ready = (state_reg == ST_IN_FILL || state_reg == ST_IN_STORE);

    always_comb
    begin
        fifo_push  = 1'b0;
        push_digit = adder_reg;
        if (!fifo_full && adder_full_reg
            && (state_reg inside {ST_OUT_PAIR, ST_OUT_HIGH, ST_FINISH}))
        begin
            fifo_push = 1'b1;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_reg        <= ST_IDLE;
            cnt_reg          <= 4'h0;
            done             <= 1'b0;
            alarm            <= ALARM_NONE;
            control_word_fetch <= 1'b0;
            fetch_index_modify <= 1'b0;
            unit_release     <= 1'b0;
            ctlw_reg         <= 1'b0;
            format_run_reg   <= 1'b0;
            reload_reg       <= 4'h0;
        end
        else
        begin
            done         <= 1'b0;
            unit_release <= 1'b0;
            unique case (state_reg)
                ST_IDLE:
                    if (start)
                    begin
                        alarm              <= ALARM_NONE;
                        control_word_fetch <= 1'b0;
                        fetch_index_modify <= 1'b0;
                        reload_reg <= control_register[`RELOAD_HI:`RELOAD_LO];
                        ctlw_reg   <= control_register[`CTLW_LO];
                        format_run_reg <= card_format_hold;
                        cnt_reg    <= 4'h0;
                        if (!unit_present)
                            alarm <= ALARM_NO_UNIT;
                        else if (dir == DIR_INPUT && !format_selected)
                            alarm <= ALARM_NO_FORMAT;
                        else if (dir == DIR_INPUT)
                            state_reg <= ST_IN_FILL;
                        else
                            state_reg <= ST_OUT_LOAD;
                    end
                ST_IN_FILL:
                    if (band_valid)
                    begin
                        // Incoming word completes after 11 digits
                        if (cnt_reg == 4'ha)
                        begin
                            cnt_reg   <= 4'h0;
                            state_reg <= ST_IN_STORE;
                        end
                        else
                            cnt_reg <= cnt_reg + 4'h1;
                    end
                    else if (band_done)
                        state_reg <= ST_FINISH;
                ST_IN_STORE:
                    if (addr_bad)
                    begin
                        alarm     <= ALARM_NO_ADDR;
                        state_reg <= ST_IDLE;
                    end
                    else if (ctl_word)
                    begin
                        control_word_fetch <= 1'b1;
                        fetch_index_modify <= iface_reg[`SIGN_LO];
                        unit_release       <= 1'b1;
                        state_reg          <= ST_FINISH;
                    end
                    else
                    begin
                        cnt_reg   <= {3'h0, band_valid};
                        state_reg <= band_done ? ST_FINISH : ST_IN_FILL;
                    end
                ST_OUT_LOAD:
                    if (addr_bad)
                    begin
                        alarm     <= ALARM_NO_ADDR;
                        state_reg <= ST_IDLE;
                    end
                    else
                    begin
                        cnt_reg   <= 4'h0;
                        state_reg <= ST_OUT_PAIR;
                    end
                ST_OUT_PAIR:
                    if (!fifo_full || !adder_full_reg)
                    begin
                        if (cnt_reg == `PAIRS_PER_WORD - 4'h1)
                        begin
                            cnt_reg   <= 4'h0;
                            state_reg <= ST_OUT_HIGH;
                        end
                        else
                            cnt_reg <= cnt_reg + 4'h1;
                    end
                ST_OUT_HIGH:
                    if (!fifo_full)
                    begin
                        if (cnt_reg == `HIGH_DIGITS - 4'h1)
                        begin
                            cnt_reg   <= 4'h0;
                            state_reg <= band_done ? ST_FINISH : ST_OUT_PAIR;
                        end
                        else
                            cnt_reg <= cnt_reg + 4'h1;
                    end
                ST_FINISH:
                    if (!buf_valid && !adder_full_reg)
                    begin
                        done      <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
            endcase
        end
    end

    // Processor clock held off for the whole transfer
    assign busy            = (state_reg != ST_IDLE);
    assign proc_clock_stop = busy;

    // ****************************************************************
    // Command register and address counter
    // ****************************************************************
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            peripheral_command_register <= '0;
        else if (state_reg == ST_IDLE && start)
            peripheral_command_register <= instr_word;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            addr_reg <= '0;
        else if (state_reg == ST_IDLE && start)
            addr_reg <= control_register[`ADDR_BITS+`ADDR_LO-1:`ADDR_LO];
        else if (mem_wr || mem_rd)
        begin
            // Wrap from zero to top of installed storage
            if (addr_reg == '0)
                addr_reg <= store_size - `ADDR_BITS'h1;
            else
                addr_reg <= addr_reg - `ADDR_BITS'h1;
        end
    end

    // ****************************************************************
    // Data path registers
    // ****************************************************************
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            data_reg       <= '0;
            iface_reg      <= '0;
            adder_reg      <= 4'h0;
            adder_full_reg <= 1'b0;
        end
        else
        begin
            if (band_ready && band_valid)
            begin
                data_reg <= {band_digit, data_reg[`WORD_BITS-1:4]};
                if (cnt_reg == 4'ha)
                    iface_reg <= {band_digit, data_reg[`WORD_BITS-1:4]};
            end
            if (state_reg == ST_OUT_LOAD && !addr_bad)
                iface_reg <= mem_rdata;
            if (state_reg == ST_OUT_PAIR && (!fifo_full || !adder_full_reg))
            begin
                data_reg  <= {iface_reg[7:4], data_reg[`WORD_BITS-1:4]};
                adder_reg <= iface_reg[3:0];
                adder_full_reg <= 1'b1;
                iface_reg <= {8'h00, iface_reg[`WORD_BITS-1:8]};
            end
            if (state_reg == ST_OUT_HIGH && !fifo_full)
            begin
                adder_reg <= data_reg[`WORD_BITS-5:`WORD_BITS-8];
                data_reg  <= {data_reg[`WORD_BITS-5:0], 4'h0};
            end
            if (state_reg == ST_OUT_HIGH && !fifo_full
                && cnt_reg == `HIGH_DIGITS - 4'h1)
                iface_reg <= mem_rdata;
            // Last digit left in the adder is flushed before done
            if (state_reg == ST_FINISH && fifo_push)
                adder_full_reg <= 1'b0;
        end
    end

    // Memory port: reads are combinational lookups at the counter address
    assign mem_addr  = addr_reg;
    assign mem_rd    = (state_reg == ST_OUT_LOAD && !addr_bad)
                       || (state_reg == ST_OUT_HIGH && !fifo_full
                           && cnt_reg == `HIGH_DIGITS - 4'h1);
    assign mem_wr    = (state_reg == ST_IN_STORE) && !addr_bad && !ctl_word;
    assign mem_wdata = store_word;

    // ****************************************************************
    // Output buffer
    // ****************************************************************
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg   <= 1'b0;
            rd_ptr_reg   <= 1'b0;
            fifo_cnt_reg <= 2'h0;
        end
        else
        begin
            if (fifo_push)
            begin
                fifo_mem[wr_ptr_reg] <= push_digit;
                wr_ptr_reg           <= ~wr_ptr_reg;
            end
            if (fifo_pop)
                rd_ptr_reg <= ~rd_ptr_reg;
            fifo_cnt_reg <= fifo_cnt_reg + {1'b0, fifo_push} - {1'b0, fifo_pop};
        end
    end

    // ****************************************************************
    // Hold bits
    // ****************************************************************
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            reload_hold <= 1'b0;
            format_hold <= 1'b0;
        end
        else if (state_reg == ST_IDLE && start && unit_present
                 && dir != DIR_OUTPUT)
        begin
            // Input and format-load instructions touch the reload hold; output leaves it
            if (dir == DIR_INPUT && card_format_hold)
            begin
                format_hold <= 1'b0;
                reload_hold <= 1'b1;
            end
            else if (control_register[`RELOAD_LO])
                reload_hold <= 1'b1;
            else
                reload_hold <= 1'b0;
        end
        else if (card_format_hold && state_reg == ST_IDLE)
            format_hold <= 1'b1;
    end

endmodule

// ==== sim/card_xfer_props.sv ====
`timescale 1ns/10ps
// ****************************************
// Port checker for the card transfer block
// ****************************************
module card_xfer_props
(
    input wire logic                        core_clk,
    input wire logic                        rst_n,
    input wire logic                        start,
    input wire card_xfer_pkg::xfer_dir_type dir,
    input wire logic [43:0]                 instr_word,
    input wire logic [43:0]                 control_register,
    input wire logic [13:0]                 store_size,
    input wire logic                        unit_present,
    input wire logic                        format_selected,
    input wire logic                        card_format_hold,
    input wire logic                        buf_valid,
    input wire logic                        buf_ready,
    input wire logic [3:0]                  buf_digit,
    input wire logic                        mem_wr,
    input wire logic                        mem_rd,
    input wire logic [13:0]                 mem_addr,
    input wire logic [43:0]                 peripheral_command_register,
    input wire logic                        proc_clock_stop,
    input wire logic                        busy,
    input wire logic                        done,
    input wire logic                        reload_hold,
    input wire logic                        format_hold,
    input wire card_xfer_pkg::alarm_type    alarm
);
    import card_xfer_pkg::*;
    logic         take;
    logic         ok;
    xfer_dir_type dir_reg;
    logic [13:0]  addr_reg;
    logic         hold_reg;
    logic         fmt_reg;
    assign take = start && !busy;
    assign ok = take && unit_present && (control_register[17:4] < store_size)
                && (dir != DIR_INPUT || format_selected);
    // Expected address walks down and wraps at the installed size
    always_ff @(posedge core_clk)
    begin
        if (ok)
        begin
            dir_reg  <= dir;
            addr_reg <= control_register[17:4];
            fmt_reg  <= dir == DIR_INPUT && card_format_hold;
            hold_reg <= (dir == DIR_OUTPUT) ? reload_hold
                        : control_register[20] || (dir == DIR_INPUT && card_format_hold);
        end
        else if (mem_wr || mem_rd)
        begin
            addr_reg <= (addr_reg == 14'h0000) ? store_size - 14'h0001 : addr_reg - 14'h0001;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    AST_BUSY_START: assert property (ok |=> busy)
        else $error("busy missing after accepted start");
    AST_CLOCK_STOP: assert property (proc_clock_stop == busy)
        else $error("processor clock stop differs from busy");
    AST_CMD_COPY: assert property (ok |=> peripheral_command_register == $past(instr_word))
        else $error("command register not loaded from instruction");
    AST_ADDR_SEQ: assert property ((mem_wr || mem_rd) |-> mem_addr == addr_reg)
        else $error("storage address out of sequence");
    AST_WR_INPUT: assert property (mem_wr |-> dir_reg == DIR_INPUT)
        else $error("storage write outside input");
    AST_RD_OUTPUT: assert property (mem_rd |-> dir_reg != DIR_INPUT)
        else $error("storage read during input");
    AST_UNIT_ALARM: assert property (take && !unit_present |=> alarm == ALARM_NO_UNIT && !busy)
        else $error("missing unit alarm");
    AST_FMT_ALARM: assert property (take && unit_present && dir == DIR_INPUT && !format_selected
        |=> alarm == ALARM_NO_FORMAT && !busy)
        else $error("missing format alarm");
    AST_FMT_OUT: assert property (take && dir != DIR_INPUT |=> alarm != ALARM_NO_FORMAT)
        else $error("format alarm on output");
    AST_RELOAD: assert property (done |-> reload_hold == hold_reg)
        else $error("reload hold wrong at end");
    AST_FMT_CLEAR: assert property (done && fmt_reg |-> !format_hold && reload_hold)
        else $error("format hold not released");
    AST_BUF_HOLD: assert property (buf_valid && !buf_ready |=> buf_valid && $stable(buf_digit))
        else $error("stalled buffer digit changed");
endmodule

bind punched_card_buffer_transfer card_xfer_props i_card_xfer_props (.*);

// ==== sim/card_side_model.sv ====
`timescale 1ns/10ps
// ****************************************
// Buffer unit digit streams and core storage
// ****************************************
module card_side_model
(
    input wire logic        core_clk,
    output logic            band_valid,
    input wire logic        band_ready,
    output logic [3:0]      band_digit,
    output logic            band_done,
    input wire logic        buf_valid,
    output logic            buf_ready,
    input wire logic [3:0]  buf_digit,
    input wire logic        mem_wr,
    input wire logic        mem_rd,
    input wire logic [13:0] mem_addr,
    input wire logic [43:0] mem_wdata,
    output logic [43:0]     mem_rdata
);
    logic [3:0]  band_q[$];
    logic [43:0] mem[int];
    logic [43:0] noise;
    logic [3:0]  last_digit;
    logic        end_flag;
    logic        stall;
    int          out_sum;
    int          out_count;
    initial
    begin
        {band_valid, band_done, buf_ready, end_flag, stall} = 5'h00;
        {band_digit, last_digit, noise, mem_rdata} = 96'h0;
        {out_sum, out_count} = 64'h0;
    end
    task automatic push_word(input logic [43:0] w);
        for (int i = 0; i < 11; i++)
        begin
            band_q.push_back(w[i*4+:4]);
        end
    endtask
    task automatic flush();
        band_q.delete();
        end_flag = 1'b0;
    endtask
    // At most one digit per cycle of the shared clock on each stream; buffer readiness is random
    always @(posedge core_clk)
    begin
        if (band_valid && band_ready)
        begin
            last_digit = band_q.pop_front();
        end
        if (buf_valid && buf_ready)
        begin
            out_sum = out_sum + int'(buf_digit);
            out_count++;
        end
        if (mem_wr)
        begin
            mem[int'(mem_addr)] = mem_wdata;
        end
        #1;
        noise = ~noise ^ 44'h5a5a5a5a5a5;
        band_valid = band_q.size() != 0;
        // Idle band shows the inverse of the last digit
        band_digit = band_valid ? band_q[0] : ~last_digit;
        band_done = end_flag && band_q.size() == 0;
        buf_ready = !stall && $urandom_range(3) != 0;
    end
    always @(mem_rd, mem_addr, noise)
    begin
        mem_rdata = !mem_rd ? noise : mem.exists(int'(mem_addr)) ? mem[int'(mem_addr)] : 44'h0;
    end
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/10ps
module tb;
    import card_xfer_pkg::*;
    logic         core_clk, rst_n, start, unit_present, format_selected, card_format_hold;
    logic         band_valid, band_ready, band_done, buf_valid, buf_ready, mem_wr, mem_rd;
    logic         proc_clock_stop, busy, done, control_word_fetch, fetch_index_modify;
    logic         unit_release;
    logic         reload_hold, format_hold;
    logic [3:0]   index_digits_sign, band_digit, buf_digit;
    logic [13:0]  store_size, index_value, mem_addr;
    logic [43:0]  instr_word, control_register, mem_wdata, mem_rdata, w;
    logic [43:0]  peripheral_command_register;
    xfer_dir_type dir;
    alarm_type    alarm;
    int           bad_count, num_checks;
    logic [57:0]  exp_q[$];
    punched_card_buffer_transfer i_punched_card_buffer_transfer (.*);
    card_side_model i_card_side_model (.*);
    always #4 core_clk = ~core_clk;
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        num_checks++;
        if (seen !== want)
        begin
            bad_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic results();
        if (bad_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ****************************************
    // Storage write scoreboard
    // ****************************************
    always @(posedge core_clk)
    begin
        if (mem_wr === 1'b1)
        begin
            check(64'({mem_addr, mem_wdata}),
                  64'(exp_q.size() ? exp_q.pop_front() : ~{mem_addr, mem_wdata}));
        end
    end
    function automatic logic [43:0] rand_word(input logic [3:0] s);
        rand_word = {40'h0, s};
        for (int i = 1; i < 11; i++)
        begin
            rand_word[i*4+:4] = 4'($urandom_range(9));
        end
    endfunction
    task automatic reset();
        rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        check(64'({reload_hold, format_hold, busy, alarm}), 64'h0);
    endtask
    // Start held two edges; the second is refused while busy
    task automatic go(input xfer_dir_type d, input logic [13:0] a, input logic [3:0] rl,
                      input logic cw);
        int n;
        @(posedge core_clk);
        #1;
        dir = d;
        instr_word = 44'({$urandom(), $urandom()});
        index_digits_sign = 4'($urandom_range(9));
        control_register = {16'h0, 3'h0, cw, rl, 2'h0, a, 4'h0};
        start = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        start = 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 3000)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check(64'(n < 3000), 64'h1);
    endtask
    task automatic card_in(input logic [13:0] a, input logic [3:0] rl, input logic cw,
                           input logic fh, input logic [11:0] signs);
        logic [13:0] ea;
        logic [3:0]  s;
        logic [3:0]  cs;
        logic        stop;
        ea = a;
        stop = 1'b0;
        cs = 4'h0;
        card_format_hold = fh;
        for (int k = 0; k < 3; k++)
        begin
            s = signs[k*4+:4];
            w = rand_word(s);
            i_card_side_model.push_word(w);
            if (!stop && !cw && (s == 4'h6 || s == 4'h7))
            begin
                stop = 1'b1;
                cs = s;
            end
            if (!stop)
            begin
                if (s >= 4'h8 && rl >= 4'h8)
                    w[3:0] = s - 4'h8;
                exp_q.push_back({ea, w});
                ea = (ea == 14'h0) ? store_size - 14'h1 : ea - 14'h1;
            end
        end
        i_card_side_model.end_flag = 1'b1;
        go(DIR_INPUT, a, rl, cw);
        check(64'(exp_q.size()), 64'h0);
        check(64'({control_word_fetch, alarm}), 64'({stop, ALARM_NONE}));
        if (stop)
            check(64'(fetch_index_modify), 64'(cs == 4'h7));
        i_card_side_model.flush();
    endtask
    initial
    begin
        {core_clk, start, card_format_hold, unit_present, format_selected} = 5'h03;
        {bad_count, num_checks} = 64'h0;
        {instr_word, control_register, index_digits_sign} = 92'h0;
        dir = DIR_INPUT;
        store_size = 14'h0040;
        index_value = 14'h0000;
        void'($urandom(32'h046b));
        reset();
        card_in(14'h0001, 4'h1, 1'b0, 1'b0, {4'h5, 4'h3, 4'h0});
        card_in(14'h0020, 4'h8, 1'b1, 1'b0, {4'h9, 4'h6, 4'h8});
        for (int sg = 6; sg < 8; sg++)
            card_in(14'h0010, 4'h0, 1'b0, 1'b1, {4'h2, 4'(sg), 4'h4});
        format_selected = 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            w = rand_word(4'($urandom_range(9)));
            i_card_side_model.mem[48] = w;
            i_card_side_model.out_sum = 0;
            i_card_side_model.out_count = 0;
            i_card_side_model.end_flag = 1'b1;
            i_card_side_model.stall = 1'b1;
            fork
                go(k ? DIR_FORMAT_LOAD : DIR_OUTPUT, 14'h0030, 4'(k * 2), 1'b0);
                begin
                    repeat (40) @(posedge core_clk);
                    #1;
                    i_card_side_model.stall = 1'b0;
                end
            join
            repeat (30) @(posedge core_clk);
            check(64'(alarm), 64'(ALARM_NONE));
            check(64'(i_card_side_model.out_count >= 11), 64'h1);
            check(64'(i_card_side_model.out_sum), 64'(w[3:0] + w[7:4] + w[11:8] + w[15:12]
                + w[19:16] + w[23:20] + w[27:24] + w[31:28] + w[35:32] + w[39:36]
                + w[43:40]));
            i_card_side_model.flush();
        end
        go(DIR_INPUT, 14'h0005, 4'h0, 1'b0);
        check(64'(alarm), 64'(ALARM_NO_FORMAT));
        format_selected = 1'b1;
        unit_present = 1'b0;
        go(DIR_OUTPUT, 14'h0005, 4'h0, 1'b0);
        check(64'(alarm), 64'(ALARM_NO_UNIT));
        unit_present = 1'b1;
        reset();
        i_card_side_model.push_word(rand_word(4'h1));
        i_card_side_model.end_flag = 1'b1;
        go(DIR_INPUT, 14'h0050, 4'h0, 1'b0);
        check(64'(alarm), 64'(ALARM_NO_ADDR));
        i_card_side_model.flush();
        results();
    end
    initial
    begin
        #400000;
        bad_count++;
        results();
    end
endmodule
